// *** ocf_pkg.sv ***
// package of the oscillator control flags block: register map, field layout, reset values
// and stabilization wait lengths.
// assumes a 32-bit apb slave with one register per aligned word.
package ocf_pkg;

  // ******************************
  // register offsets (byte addresses)
  // ******************************
  localparam logic [11:0] OCF_LS_CTRL_OFS = 12'h000;
  localparam logic [11:0] OCF_HS_CTRL_OFS = 12'h004;
  localparam logic [11:0] OCF_FLAGS_OFS   = 12'h008;
  localparam logic [11:0] OCF_IRQ_EN_OFS  = 12'h00c;
  localparam logic [11:0] OCF_SRC_EN_OFS  = 12'h010;

  // ******************************
  // field positions
  // ******************************
  localparam int OCF_LS_RESTART_BIT = 14;
  localparam int OCF_LS_DET_BIT     = 13;
  localparam int OCF_LS_BOOST_BIT   = 12;
  localparam int OCF_LS_CAP_LSB     = 8;
  localparam int OCF_LS_BGAIN_LSB   = 6;
  localparam int OCF_LS_NGAIN_LSB   = 4;
  localparam int OCF_LS_WAIT_LSB    = 0;
  localparam int OCF_HS_FREQ_LSB    = 10;
  localparam int OCF_HS_TYPE_LSB    = 8;
  localparam int OCF_HS_GAIN_LSB    = 4;
  localparam int OCF_HS_WAIT_LSB    = 0;
  localparam int OCF_F_INT_STABLE   = 0;
  localparam int OCF_F_LS_STABLE    = 1;
  localparam int OCF_F_HS_STABLE    = 2;
  localparam int OCF_F_TRIM_DONE    = 4;
  localparam int OCF_F_LS_STOP      = 5;
  localparam int OCF_SRC_INT        = 0;
  localparam int OCF_SRC_LS         = 1;
  localparam int OCF_SRC_HS         = 2;

  // ******************************
  // writable masks and reset values
  // ******************************
  localparam logic [15:0] OCF_LS_CTRL_MASK  = 16'h77f3;
  localparam logic [15:0] OCF_HS_CTRL_MASK  = 16'h1f37;
  localparam logic [15:0] OCF_FLAGS_MASK    = 16'h0037;
  localparam logic [15:0] OCF_LS_CTRL_RST   = 16'h5092;
  localparam logic [15:0] OCF_HS_CTRL_RST   = 16'h0c16;
  localparam logic [15:0] OCF_FLAGS_RST     = 16'h0000;
  localparam logic [15:0] OCF_IRQ_EN_RST    = 16'h0000;
  localparam logic [2:0]  OCF_SRC_EN_RST    = 3'h1;

  // ******************************
  // high-speed oscillator type codes
  // ******************************
  typedef enum logic [1:0] {
    OCF_HS_INTERNAL = 2'b00,
    OCF_HS_CR       = 2'b01,
    OCF_HS_XTAL     = 2'b10,
    OCF_HS_RSVD     = 2'b11
  } ocf_hs_type_t;

  // ******************************
  // stabilization wait lengths in oscillator clocks
  // ******************************
  localparam int          OCF_WAIT_W     = 17;
  localparam int          OCF_CLK_NS     = 4;
  localparam int          OCF_SYNC_W     = 5;
  localparam logic [16:0] OCF_LS_WAIT_1  = 17'h01000;
  localparam logic [16:0] OCF_HS_WAIT_0  = 17'h00004;
  localparam logic [16:0] OCF_HS_WAIT_1  = 17'h00010;
  localparam logic [16:0] OCF_HS_WAIT_2  = 17'h00040;
  localparam logic [16:0] OCF_HS_WAIT_3  = 17'h00100;
  localparam logic [16:0] OCF_HS_WAIT_4  = 17'h00400;
  localparam logic [16:0] OCF_HS_WAIT_5  = 17'h01000;
  localparam logic [16:0] OCF_INT_WAIT   = 17'h00400;

endpackage

// *** ocf_stab_wait.sv ***
// one stabilization wait counter for one oscillator source.
// assumes tick is a one-cycle pulse per oscillator clock, already synchronised.
`timescale 1ns/1ps
module ocf_stab_wait #(
  parameter int CW = 17
) (
  input  wire logic          clk_i,    // system clock
  input  wire logic          rst_i,    // synchronous reset, active high
  input  wire logic          ce_i,     // clock enable
  input  wire logic          start_i,  // source enable rose
  input  wire logic          en_i,     // source enable level
  input  wire logic          tick_i,   // one oscillator clock seen
  input  wire logic [CW-1:0] len_i,    // wait length in oscillator clocks
  output logic               busy_o,   // waiting for stabilization
  output logic               done_o    // one-cycle pulse at end of wait
);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          busy_q;
  logic          busy_d;
  logic          hit;

  assign hit    = busy_q & tick_i & (cnt_q + CW'(1) >= len_i);
  assign done_o = hit & ce_i;
  assign busy_o = busy_q;

  // ******************************
  // count oscillator clocks up to the selected length
  // ******************************
  always_comb
  begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    if (start_i)
    begin
      cnt_d  = '0;
      busy_d = 1'b1;
    end
    else if (!en_i || hit)
    begin
      busy_d = 1'b0;
    end
    else if (busy_q && tick_i)
    begin
      cnt_d = cnt_q + CW'(1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end
    else if (ce_i)
    begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
    end
  end

endmodule // ocf_stab_wait

// *** ocf_top.sv ***
// oscillator control flags: low/high-speed oscillator control fields, source enables,
// stabilization wait counters and write-one-to-clear cause flags behind an apb slave.
// assumes analog oscillator signals arrive asynchronously and are resynchronised here.
//
// What this block does
// - stop detected with restart enabled restarts oscillator
// - detector enable bit switches stop detector
// - boost bit activates booster during startup
// - three-bit field selects gate capacitance
// - two-bit field sets boosted startup gain
// - two-bit field sets normal operation gain
// - low-speed wait codes give 4096/16384/65536 clocks
// - internal-type frequency code drives oscillator frequency
// - type field selects internal, cr, crystal
// - high-speed gain applies only to crystal type
// - high-speed wait is four to 65536 clocks
// - stop and trim-done events set flags
// - each source sets stable flag at wait end
// - writing one clears flag, zero ignored
// - internal stable flag reads zero after reset
// - enabled causes alone raise interrupt request
`timescale 1ns/1ps
module ocf_top
  import ocf_pkg::*;
#(
  parameter logic [16:0] LS_WAIT_2 = 17'h04000,  // 16384 low-speed clocks
  parameter logic [16:0] LS_WAIT_3 = 17'h10000,  // 65536 low-speed clocks
  parameter logic [16:0] HS_WAIT_6 = 17'h04000,  // 16384 high-speed clocks
  parameter logic [16:0] HS_WAIT_7 = 17'h10000   // 65536 high-speed clocks
) (
  input  wire logic        REF_CLK_I,       // system clock, 250 mhz
  input  wire logic        SYS_RST_I,       // synchronous reset, active high
  input  wire logic        CE_I,            // clock enable, freezes state when low
  input  wire logic        PSEL_I,          // apb select
  input  wire logic        PENABLE_I,       // apb enable
  input  wire logic        PWRITE_I,        // apb direction
  input  wire logic [11:0] PADDR_I,         // apb byte address
  input  wire logic [31:0] PWDATA_I,        // apb write data
  output logic      [31:0] PRDATA_O,        // apb read data
  output logic             PREADY_O,        // apb ready
  output logic             PSLVERR_O,       // apb error, unmapped address
  input  wire logic        WPROT_OPEN_I,    // system write protection released
  input  wire logic        LS_CLK_I,        // low-speed oscillator clock
  input  wire logic        HS_CLK_I,        // high-speed oscillator clock
  input  wire logic        INT_CLK_I,       // internal oscillator clock
  input  wire logic        LS_STOPPED_I,    // stop detector reports oscillation stopped
  input  wire logic        TRIM_DONE_I,     // auto-trimming finished level
  output logic             LS_EN_O,         // low-speed oscillator run
  output logic             HS_EN_O,         // high-speed oscillator run
  output logic             INT_EN_O,        // internal oscillator run
  output logic             LS_RESTART_O,    // one-cycle restart pulse
  output logic             LS_DET_EN_O,     // stop detector on
  output logic             LS_BOOST_O,      // booster active
  output logic      [2:0]  LS_GATE_CAP_O,   // gate capacitance code
  output logic      [1:0]  LS_GAIN_O,       // inverter gain in use
  output logic      [2:0]  HS_FREQ_O,       // internal-type frequency code
  output logic      [1:0]  HS_TYPE_O,       // oscillator type code
  output logic      [1:0]  HS_GAIN_O,       // crystal inverter gain
  output logic             IRQ_O            // interrupt request
);

  // ******************************
  // registers and declarations
  // ******************************
  logic [15:0]           ls_ctrl_q;
  logic [15:0]           ls_ctrl_d;
  logic [15:0]           hs_ctrl_q;
  logic [15:0]           hs_ctrl_d;
  logic [15:0]           flags_q;
  logic [15:0]           flags_d;
  logic [15:0]           irq_en_q;
  logic [15:0]           irq_en_d;
  logic [2:0]            src_en_q;
  logic [2:0]            src_en_d;
  logic [31:0]           rdata_q;
  logic [OCF_SYNC_W-1:0] sync1_q;
  logic [OCF_SYNC_W-1:0] sync2_q;
  logic [OCF_SYNC_W-1:0] sync3_q;
  logic [OCF_SYNC_W-1:0] rise;
  logic [OCF_SYNC_W-1:0] async_in;
  logic                  restart_q;

  wire                   setup_ph = PSEL_I & ~PENABLE_I;
  wire                   access_ph = PSEL_I & PENABLE_I;
  wire                   wr_en = access_ph & PWRITE_I;
  wire                   sel_ls = PADDR_I == OCF_LS_CTRL_OFS;
  wire                   sel_hs = PADDR_I == OCF_HS_CTRL_OFS;
  wire                   sel_flags = PADDR_I == OCF_FLAGS_OFS;
  wire                   sel_irq = PADDR_I == OCF_IRQ_EN_OFS;
  wire                   sel_src = PADDR_I == OCF_SRC_EN_OFS;
  wire                   mapped = sel_ls | sel_hs | sel_flags | sel_irq | sel_src;
  wire                   wr_ls = wr_en & sel_ls & WPROT_OPEN_I;
  wire                   wr_hs = wr_en & sel_hs & WPROT_OPEN_I;
  wire                   wr_flags = wr_en & sel_flags;
  wire                   wr_irq = wr_en & sel_irq;
  wire                   wr_src = wr_en & sel_src;

  // ******************************
  // apb answer: zero wait states, error on unmapped address
  // ******************************
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = access_ph & ~mapped;
  assign PRDATA_O  = rdata_q;

  wire [15:0] rd_mux = sel_ls    ? ls_ctrl_q :
                       sel_hs    ? hs_ctrl_q :
                       sel_flags ? flags_q :
                       sel_irq   ? irq_en_q :
                       sel_src   ? {13'h0000, src_en_q} : 16'h0000;

  // ******************************
  // input synchronisers; third stage only for edge detection
  // ******************************
  assign async_in = {LS_STOPPED_I, TRIM_DONE_I, HS_CLK_I, LS_CLK_I, INT_CLK_I};
  assign rise     = sync2_q & ~sync3_q;

  wire int_tick  = rise[0];
  wire ls_tick   = rise[1];
  wire hs_tick   = rise[2];
  wire trim_rise = rise[3];
  wire stop_rise = rise[4];

  // ******************************
  // control fields to the analog side
  // ******************************
  wire       det_en     = ls_ctrl_q[OCF_LS_DET_BIT];
  wire       restart_en = ls_ctrl_q[OCF_LS_RESTART_BIT];
  wire       boost_en   = ls_ctrl_q[OCF_LS_BOOST_BIT];
  wire [1:0] boost_gain = ls_ctrl_q[OCF_LS_BGAIN_LSB +: 2];
  wire [1:0] norm_gain  = ls_ctrl_q[OCF_LS_NGAIN_LSB +: 2];
  wire [1:0] ls_wait    = ls_ctrl_q[OCF_LS_WAIT_LSB +: 2];
  wire [2:0] hs_wait    = hs_ctrl_q[OCF_HS_WAIT_LSB +: 3];
  wire [1:0] hs_type    = hs_ctrl_q[OCF_HS_TYPE_LSB +: 2];
  wire [2:0] busy;
  wire [2:0] done;
  wire [2:0] start;
  wire [2:0] tick = {hs_tick, ls_tick, int_tick};
  wire       ls_boosting = boost_en & busy[OCF_SRC_LS] & src_en_q[OCF_SRC_LS];

  // stop is only believed while the detector is on
  wire       stop_evt = stop_rise & det_en;
  wire       restart = stop_evt & restart_en & src_en_q[OCF_SRC_LS];

  assign LS_EN_O       = src_en_q[OCF_SRC_LS];
  assign HS_EN_O       = src_en_q[OCF_SRC_HS];
  assign INT_EN_O      = src_en_q[OCF_SRC_INT];
  assign LS_RESTART_O  = restart_q;
  assign LS_DET_EN_O   = det_en;
  assign LS_BOOST_O    = ls_boosting;
  assign LS_GATE_CAP_O = ls_ctrl_q[OCF_LS_CAP_LSB +: 3];
  assign LS_GAIN_O     = ls_boosting ? boost_gain : norm_gain;
  assign HS_FREQ_O     = hs_ctrl_q[OCF_HS_FREQ_LSB +: 3];
  assign HS_TYPE_O     = hs_type;
  // gain is forced to minimum unless a crystal is in use
  assign HS_GAIN_O     = (hs_type == OCF_HS_XTAL) ? hs_ctrl_q[OCF_HS_GAIN_LSB +: 2]
                                                  : 2'h0;
  assign IRQ_O         = |(flags_q & irq_en_q & OCF_FLAGS_MASK);

  // ******************************
  // wait lengths
  // ******************************
  logic [OCF_WAIT_W-1:0] ls_len;
  logic [OCF_WAIT_W-1:0] hs_len;

  // reserved low-speed code 0 takes the longest wait, the safe side
  always_comb
  begin
    case (ls_wait)
      2'h1:    ls_len = OCF_LS_WAIT_1;
      2'h2:    ls_len = LS_WAIT_2;
      default: ls_len = LS_WAIT_3;
    endcase
  end

  always_comb
  begin
    case (hs_wait)
      3'h0:    hs_len = OCF_HS_WAIT_0;
      3'h1:    hs_len = OCF_HS_WAIT_1;
      3'h2:    hs_len = OCF_HS_WAIT_2;
      3'h3:    hs_len = OCF_HS_WAIT_3;
      3'h4:    hs_len = OCF_HS_WAIT_4;
      3'h5:    hs_len = OCF_HS_WAIT_5;
      3'h6:    hs_len = HS_WAIT_6;
      default: hs_len = HS_WAIT_7;
    endcase
  end

  wire [OCF_WAIT_W-1:0] len [3];
  assign len[OCF_SRC_INT] = OCF_INT_WAIT;
  assign len[OCF_SRC_LS]  = ls_len;
  assign len[OCF_SRC_HS]  = hs_len;

  // counters start only on a rising enable or a low-speed restart, so the internal oscillator
  // that runs out of reset never reports stable by itself
  assign start = src_en_d & ~src_en_q
               | {1'b0, restart, 1'b0};

  // ******************************
  // stabilization counters, one per source
  // ******************************
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_wait
      ocf_stab_wait #(
        .CW      (OCF_WAIT_W)
      ) u_wait (
        .clk_i   (REF_CLK_I),
        .rst_i   (SYS_RST_I),
        .ce_i    (CE_I),
        .start_i (start[gi]),
        .en_i    (src_en_q[gi]),
        .tick_i  (tick[gi]),
        .len_i   (len[gi]),
        .busy_o  (busy[gi]),
        .done_o  (done[gi])
      );
    end
  endgenerate

  // ******************************
  // next register values
  // ******************************
  logic [15:0] flag_set;
  logic [15:0] flag_clr;

  always_comb
  begin
    flag_set                   = 16'h0000;
    flag_set[OCF_F_INT_STABLE] = done[OCF_SRC_INT];
    flag_set[OCF_F_LS_STABLE]  = done[OCF_SRC_LS];
    flag_set[OCF_F_HS_STABLE]  = done[OCF_SRC_HS];
    flag_set[OCF_F_TRIM_DONE]  = trim_rise;
    flag_set[OCF_F_LS_STOP]    = stop_evt;
    flag_clr = wr_flags ? (PWDATA_I[15:0] & OCF_FLAGS_MASK) : 16'h0000;
    // a new event in the clearing cycle survives
    flags_d  = ((flags_q & ~flag_clr) | flag_set) & OCF_FLAGS_MASK;
  end

  always_comb
  begin
    ls_ctrl_d = ls_ctrl_q;
    hs_ctrl_d = hs_ctrl_q;
    irq_en_d  = irq_en_q;
    src_en_d  = src_en_q;
    if (wr_ls)
    begin
      ls_ctrl_d = PWDATA_I[15:0] & OCF_LS_CTRL_MASK;
    end
    if (wr_hs)
    begin
      hs_ctrl_d = PWDATA_I[15:0] & OCF_HS_CTRL_MASK;
    end
    if (wr_irq)
    begin
      irq_en_d = PWDATA_I[15:0] & OCF_FLAGS_MASK;
    end
    if (wr_src)
    begin
      src_en_d = PWDATA_I[2:0];
    end
  end

  // ******************************
  // state
  // ******************************
  always_ff @(posedge REF_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      ls_ctrl_q <= OCF_LS_CTRL_RST;
      hs_ctrl_q <= OCF_HS_CTRL_RST;
      flags_q   <= OCF_FLAGS_RST;
      irq_en_q  <= OCF_IRQ_EN_RST;
      src_en_q  <= OCF_SRC_EN_RST;
      rdata_q   <= 32'h00000000;
      restart_q <= 1'b0;
    end
    else if (CE_I)
    begin
      ls_ctrl_q <= ls_ctrl_d;
      hs_ctrl_q <= hs_ctrl_d;
      flags_q   <= flags_d;
      irq_en_q  <= irq_en_d;
      src_en_q  <= src_en_d;
      restart_q <= restart;
      if (setup_ph && !PWRITE_I)
      begin
        rdata_q <= {16'h0000, rd_mux};
      end
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end
    else if (CE_I)
    begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

endmodule // ocf_top

// *** ocf_properties.sv ***
// port-level properties of the oscillator control flags block.
// assumes it is bound to ocf_top and sees only its ports.
`timescale 1ns/1ps
module ocf_properties
  import ocf_pkg::*;
(
  input wire logic        REF_CLK_I,     // clock
  input wire logic        SYS_RST_I,     // reset
  input wire logic        CE_I,          // clock enable
  input wire logic        PSEL_I,        // apb select
  input wire logic        PENABLE_I,     // apb enable
  input wire logic        PWRITE_I,      // apb direction
  input wire logic [11:0] PADDR_I,       // apb address
  input wire logic [31:0] PWDATA_I,      // apb write data
  input wire logic        PSLVERR_O,     // apb error
  input wire logic        WPROT_OPEN_I,  // protection released
  input wire logic        LS_EN_O,       // low-speed run
  input wire logic        LS_RESTART_O,  // restart pulse
  input wire logic        LS_DET_EN_O,   // detector on
  input wire logic        LS_BOOST_O,    // booster on
  input wire logic [2:0]  LS_GATE_CAP_O, // gate capacitance
  input wire logic [2:0]  HS_FREQ_O,     // frequency code
  input wire logic [1:0]  HS_TYPE_O,     // type code
  input wire logic [1:0]  HS_GAIN_O,     // crystal gain
  input wire logic        IRQ_O          // interrupt request
);
  // ******************************
  // access decoding
  // ******************************
  wire logic acc    = PSEL_I && PENABLE_I;
  wire logic wr     = acc && PWRITE_I && CE_I;
  wire logic wr_ls  = wr && PADDR_I == OCF_LS_CTRL_OFS && WPROT_OPEN_I;
  wire logic wr_hs  = wr && PADDR_I == OCF_HS_CTRL_OFS && WPROT_OPEN_I;
  wire logic wr_src = wr && PADDR_I == OCF_SRC_EN_OFS;
  wire logic wr_ien = wr && PADDR_I == OCF_IRQ_EN_OFS;
  wire logic mapped = PADDR_I inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h010};

  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  sequence s_one_pulse;
    LS_RESTART_O ##1 !LS_RESTART_O;
  endsequence

  property p_det;
    !$stable(LS_DET_EN_O) |-> $past(wr_ls) && LS_DET_EN_O == $past(PWDATA_I[13]);
  endproperty
  a_det: assert property (p_det) else $error("detector enable moved without write");
  property p_cap;
    !$stable(LS_GATE_CAP_O) |-> $past(wr_ls) && LS_GATE_CAP_O == $past(PWDATA_I[10:8]);
  endproperty
  a_cap: assert property (p_cap) else $error("gate capacitance wrong");
  property p_hs;
    !$stable({HS_FREQ_O, HS_TYPE_O}) |->
      $past(wr_hs) && {HS_FREQ_O, HS_TYPE_O} == $past(PWDATA_I[12:8]);
  endproperty
  a_hs: assert property (p_hs) else $error("frequency or type wrong");
  property p_gain;
    HS_GAIN_O != 2'h0 |-> HS_TYPE_O == OCF_HS_XTAL;
  endproperty
  a_gain: assert property (p_gain) else $error("gain outside crystal type");
  property p_restart;
    $rose(LS_RESTART_O) |-> (LS_EN_O && LS_DET_EN_O) ##0 s_one_pulse;
  endproperty
  a_restart: assert property (p_restart) else $error("restart pulse wrong");
  property p_boost;
    LS_BOOST_O |-> LS_EN_O;
  endproperty
  a_boost: assert property (p_boost) else $error("boost without oscillator");
  property p_src;
    !$stable(LS_EN_O) |-> $past(wr_src) && LS_EN_O == $past(PWDATA_I[OCF_SRC_LS]);
  endproperty
  a_src: assert property (p_src) else $error("source enable wrong");
  property p_irq;
    wr_ien && PWDATA_I[5:0] == 6'h00 |=> !IRQ_O;
  endproperty
  a_irq: assert property (p_irq) else $error("request with all masked");
  property p_err;
    PSLVERR_O == (acc && !mapped);
  endproperty
  a_err: assert property (p_err) else $error("slave error wrong");
endmodule // ocf_properties

bind ocf_top ocf_properties u_props (.REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I), .CE_I(CE_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PWDATA_I(PWDATA_I), .PSLVERR_O(PSLVERR_O), .WPROT_OPEN_I(WPROT_OPEN_I), .LS_EN_O(LS_EN_O),
  .LS_RESTART_O(LS_RESTART_O), .LS_DET_EN_O(LS_DET_EN_O), .LS_BOOST_O(LS_BOOST_O),
  .LS_GATE_CAP_O(LS_GATE_CAP_O), .HS_FREQ_O(HS_FREQ_O), .HS_TYPE_O(HS_TYPE_O),
  .HS_GAIN_O(HS_GAIN_O), .IRQ_O(IRQ_O));

// *** ocf_osc_model.sv ***
// behavioural model of the analog oscillators, stop detector and trimming circuit.
// assumes enables and restart come from ocf_top, commands from the testbench.
`timescale 1ns/1ps
module ocf_osc_model (
  input  wire logic ls_en_i,            // low-speed run
  input  wire logic hs_en_i,            // high-speed run
  input  wire logic int_en_i,           // internal run
  input  wire logic restart_i,          // restart pulse
  input  wire logic stop_cmd_i,         // make low-speed stop
  input  wire logic trim_cmd_i,         // finish trimming
  output logic      ls_clk_o = 1'b0,    // low-speed clock
  output logic      hs_clk_o = 1'b0,    // high-speed clock
  output logic      int_clk_o = 1'b0,   // internal clock
  output logic      stopped_o,          // stop reported
  output logic      trim_done_o         // trimming finished
);
  logic halted = 1'b0;
  // clocks stand still low while off, so no count can come from a dead source
  always #20 ls_clk_o = ls_en_i && !halted ? !ls_clk_o : 1'b0;
  always #16 hs_clk_o = hs_en_i ? !hs_clk_o : 1'b0;
  always #24 int_clk_o = int_en_i ? !int_clk_o : 1'b0;
  always @(posedge stop_cmd_i) halted = 1'b1;
  always @(posedge restart_i) halted = 1'b0;
  // the detector reports even when switched off, so gating must happen in the block
  assign stopped_o   = stop_cmd_i;
  assign trim_done_o = trim_cmd_i;
endmodule // ocf_osc_model

// *** oscillator_control_flags_test.sv ***
// self-checking testbench of the oscillator control flags block.
// assumes ocf_top with shortened wait parameters and the oscillator model.
`timescale 1ns/1ps
module oscillator_control_flags_test;
  import ocf_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic        wprot = 1'b1, ce = 1'b1, stop_cmd = 1'b0, trim_cmd = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  wire  logic [31:0] prdata;
  wire  logic  pready, pslverr, ls_clk, hs_clk, int_clk, stopped, trim, ls_en, hs_en, int_en;
  wire  logic  restart, det, boost, irq;
  wire  logic [2:0] cap, freq;
  wire  logic [1:0] gain, htype, hgain;
  int          errors = 0, n_checks = 0, n_restart = 0;
  logic [11:0] ofs[5] = '{OCF_LS_CTRL_OFS, OCF_HS_CTRL_OFS, OCF_FLAGS_OFS, OCF_IRQ_EN_OFS,
                          OCF_SRC_EN_OFS};
  logic [31:0] rstv[5] = '{32'(OCF_LS_CTRL_RST), 32'(OCF_HS_CTRL_RST), 32'(OCF_FLAGS_RST),
                           32'(OCF_IRQ_EN_RST), 32'(OCF_SRC_EN_RST)};
  int          hc[7] = '{0, 1, 2, 3, 4, 6, 7};

  always #2 clk = ~clk;
  always @(posedge clk) if (restart === 1'b1) n_restart++;

  ocf_top #(.LS_WAIT_2(17'h00008), .LS_WAIT_3(17'h00010), .HS_WAIT_6(17'h00008),
    .HS_WAIT_7(17'h00010)) dut (.REF_CLK_I(clk), .SYS_RST_I(rst), .CE_I(ce), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .WPROT_OPEN_I(wprot), .LS_CLK_I(ls_clk),
    .HS_CLK_I(hs_clk), .INT_CLK_I(int_clk), .LS_STOPPED_I(stopped), .TRIM_DONE_I(trim),
    .LS_EN_O(ls_en), .HS_EN_O(hs_en), .INT_EN_O(int_en), .LS_RESTART_O(restart),
    .LS_DET_EN_O(det), .LS_BOOST_O(boost), .LS_GATE_CAP_O(cap), .LS_GAIN_O(gain),
    .HS_FREQ_O(freq), .HS_TYPE_O(htype), .HS_GAIN_O(hgain), .IRQ_O(irq));
  ocf_osc_model osc (.ls_en_i(ls_en), .hs_en_i(hs_en), .int_en_i(int_en), .restart_i(restart),
    .stop_cmd_i(stop_cmd), .trim_cmd_i(trim_cmd), .ls_clk_o(ls_clk), .hs_clk_o(hs_clk),
    .int_clk_o(int_clk), .stopped_o(stopped), .trim_done_o(trim));

  // ******************************
  // shared tasks
  // ******************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic we, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= we;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  // waits through are timed from enable to flag; the window runs from (n - 1) * p to p / 2 + 12 clocks past it, wider than one period p
  task automatic wait_stable(input int b, input logic [31:0] src, input int n, input int p);
    time t0;
    int  el;
    xfer(1'b1, OCF_SRC_EN_OFS, 32'h1, rd, err);
    xfer(1'b1, OCF_FLAGS_OFS, 32'h37, rd, err);
    xfer(1'b1, OCF_SRC_EN_OFS, src, rd, err);
    t0 = $time;
    rd = 32'h0;
    repeat (2) @(negedge clk);
    if (b == OCF_F_LS_STABLE) check({29'h0, boost, gain}, 32'h7);
    while (rd[b] !== 1'b1 && $time - t0 < 40000) xfer(1'b0, OCF_FLAGS_OFS, 32'h0, rd, err);
    el = int'(($time - t0) / 4);
    check({31'h0, el >= (n - 1) * p && el <= (n - 1) * p + p / 2 + 12}, 32'h1);
  endtask

  task automatic stop_pulse(input logic [31:0] ls, input logic [31:0] exp);
    xfer(1'b1, OCF_LS_CTRL_OFS, ls, rd, err);
    xfer(1'b1, OCF_FLAGS_OFS, 32'h37, rd, err);
    n_restart = 0;
    stop_cmd <= 1'b1;
    repeat (20) @(posedge clk);
    stop_cmd <= 1'b0;
    xfer(1'b0, OCF_FLAGS_OFS, 32'h0, rd, err);
    check({rd[OCF_F_LS_STOP], 31'(n_restart)}, exp);
  endtask

  task automatic test_done();
    if (errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ******************************
  // tests
  // ******************************
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (ofs[k])
    begin
      xfer(1'b0, ofs[k], 32'h0, rd, err);
      check(rd, rstv[k]);
    end
    check({17'h0, ls_en, hs_en, int_en, cap, gain, freq, htype, hgain}, 32'h10b0);
    xfer(1'b1, 12'h020, 32'hffff, rd, err);
    check({31'h0, err}, 32'h1);
    xfer(1'b0, 12'h020, 32'h0, rd, err);
    check({rd[30:0], err}, 32'h1);
    wprot <= 1'b0;
    xfer(1'b1, OCF_LS_CTRL_OFS, 32'h0700, rd, err);
    {wprot, ce} <= 2'h2;
    xfer(1'b1, OCF_LS_CTRL_OFS, 32'h0700, rd, err);
    ce <= 1'b1;
    xfer(1'b0, OCF_LS_CTRL_OFS, 32'h0, rd, err);
    check(rd, 32'(OCF_LS_CTRL_RST));
    for (int i = 0; i < 8; i++)
    begin
      // boost gain 3 stays at or above the normal gain
      xfer(1'b1, OCF_LS_CTRL_OFS, 32'h00c2 | (i << 8) | ((i % 4) << 4), rd, err);
      xfer(1'b1, OCF_HS_CTRL_OFS, ((i % 6) << 10) | ((i % 3) << 8) | 32'h36, rd, err);
      xfer(1'b0, OCF_HS_CTRL_OFS, 32'h0, rd, err);
      check(rd, ((i % 6) << 10) | ((i % 3) << 8) | 32'h36);
      check({cap, gain, freq, htype, hgain}, {3'(i), 2'(i % 4), 3'(i % 6), 2'(i % 3),
            (i % 3 == 2) ? 2'h3 : 2'h0});
    end
    foreach (hc[k])
    begin
      xfer(1'b1, OCF_HS_CTRL_OFS, 32'h0c10 | hc[k], rd, err);
      wait_stable(OCF_F_HS_STABLE, 32'h5, hc[k] > 5 ? 8 << (hc[k] - 6) : 4 << (2 * hc[k]), 8);
    end
    for (int c = 2; c < 4; c++)
    begin
      xfer(1'b1, OCF_LS_CTRL_OFS, 32'h50d0 | c, rd, err);
      wait_stable(OCF_F_LS_STABLE, 32'h3, 8 << (c - 2), 10);
      check({29'h0, boost, gain}, 32'h1);
    end
    xfer(1'b1, OCF_IRQ_EN_OFS, 32'h2, rd, err);
    @(negedge clk);
    check({31'h0, irq}, 32'h1);
    xfer(1'b1, OCF_FLAGS_OFS, 32'h0, rd, err);
    xfer(1'b0, OCF_FLAGS_OFS, 32'h0, rd, err);
    check(rd, 32'h2);
    xfer(1'b1, OCF_FLAGS_OFS, 32'h2, rd, err);
    xfer(1'b0, OCF_FLAGS_OFS, 32'h0, rd, err);
    check({rd[30:0], irq}, 32'h0);
    xfer(1'b1, OCF_IRQ_EN_OFS, 32'h0, rd, err);
    // detector is switched on only now that the low-speed clock is stable
    stop_pulse(32'h70d3, 32'h80000001);
    stop_pulse(32'h30d3, 32'h80000000);
    stop_pulse(32'h50d3, 32'h00000000);
    trim_cmd <= 1'b1;
    repeat (8) @(posedge clk);
    trim_cmd <= 1'b0;
    xfer(1'b0, OCF_FLAGS_OFS, 32'h0, rd, err);
    check({31'h0, rd[OCF_F_TRIM_DONE]}, 32'h1);
    xfer(1'b1, OCF_LS_CTRL_OFS, 32'h10d3, rd, err);
    xfer(1'b1, OCF_SRC_EN_OFS, 32'h1, rd, err);
    test_done();
  end

  initial
  begin
    repeat (30000) @(posedge clk);
    errors++;
    test_done();
  end
endmodule // oscillator_control_flags_test
